// ==== rtl/pcr_map.svh ====
// Offsets, field positions, masks and reset values of the PLL-1 configuration slice
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

`define PCR_OFS_PREDIV        8'h20
`define PCR_OFS_SRC_BYP       8'h21
`define PCR_OFS_PUMP_GAIN     8'h28
`define PCR_OFS_PUMP_OFS      8'h29

`define PCR_RST_PREDIV        8'h01
`define PCR_RST_SRC_BYP       8'h90
`define PCR_RST_PUMP_GAIN     8'h30
`define PCR_RST_PUMP_OFS      8'h00

`define PCR_MSK_PREDIV        8'hFF
`define PCR_MSK_SRC_BYP       8'hF8
`define PCR_MSK_PUMP_GAIN     8'hBF
`define PCR_MSK_PUMP_OFS      8'h3F

`define PCR_BIT_DOUBLER       7
`define PCR_BIT_FB_HALF       7
`define PCR_BIT_EXT_HALF      6
`define PCR_BIT_SRC_HI        5
`define PCR_BIT_SRC_LO        4
`define PCR_BIT_BYPASS        3
`define PCR_BIT_PUMP_PD       7
`define PCR_BIT_SINK_EN       5
`define PCR_BIT_STEP_X2       4

`define PCR_STEP_X2_BASE      5'h10
`define PCR_PREDIV_MIN        7'h01

`endif

// ==== rtl/pcr_pkg.sv ====
// Types shared by the PLL-1 configuration slice
package pcr_pkg;
    typedef enum logic [1:0] {
        PCR_SRC_EXT_VCO  = 2'b00,
        PCR_SRC_STAGE2   = 2'b01,
        PCR_SRC_STAGE1   = 2'b10,
        PCR_SRC_REF_CLK  = 2'b11
    } pcr_src_e;
    typedef logic [7:0] pcr_byte_t;
endpackage

// ==== rtl/pcr_decode.sv ====
// Decode of the stored configuration bytes into analog control values
`timescale 1ns/1ps
`default_nettype none
`include "pcr_map.svh"
module pcr_decode
    import pcr_pkg::*;
(
    input  wire pcr_byte_t   prediv_reg,
    input  wire pcr_byte_t   gain_reg,
    input  wire pcr_byte_t   ofs_reg,
    output logic [6:0]       divide_ratio,
    output logic [4:0]       pump_current,
    output logic [5:0]       offset_current
);
    logic [6:0] p_raw;
    logic       step_x2;
    logic [3:0] gain;

    always_comb begin
        p_raw   = prediv_reg[6:0];
        step_x2 = gain_reg[`PCR_BIT_STEP_X2];
        gain    = gain_reg[3:0];
        // Doubler path ignores the pre-divider; code 0 treated as divide by one
        if (prediv_reg[`PCR_BIT_DOUBLER] || p_raw == 7'h00) begin
            divide_ratio = `PCR_PREDIV_MIN;
        end else begin
            divide_ratio = p_raw;
        end
        // Pump current in 100 uA units; powered-down pump carries none
        if (gain_reg[`PCR_BIT_PUMP_PD]) begin
            pump_current = 5'h00;
        end else if (step_x2) begin
            pump_current = `PCR_STEP_X2_BASE + {1'b0, gain[2:0], 1'b0};
        end else begin
            pump_current = {1'b0, gain};
        end
        // Offset in 12.5 uA units: weights 16,8,8,4,2,1
        offset_current = {1'b0, ofs_reg[5], 4'h0} + {2'h0, ofs_reg[4], 3'h0}
                       + {2'h0, ofs_reg[3], 3'h0} + {3'h0, ofs_reg[2:0]};
    end
endmodule
`default_nettype wire

// ==== rtl/pcr_regs.sv ====
// PLL-1 input, bypass and charge pump configuration registers
// Function
// - Doubler select 0 feeds stage two through the pre-divider, 1 doubles and ignores it.
// - The seven-bit pre-divider is a binary ratio 1 to 127, resetting to 1 (bypassed).
// - Feedback halving select, reset 1, halves the VCXO ahead of the feedback divider.
// - External VCO halving select, reset 0, halves the external VCO when set.
// - Source select routes external VCO 00, stage two 01 (reset), stage one 10, reference 11.
// - Mode bit 0 (reset) is dual PLL, 1 is synthesizer mode with stage one bypassed.
// - Pump power-down 0 (reset) keeps the pump on, 1 powers it down and disables it.
// - Sink enable 1 (reset) enables equal sink current, 0 disables it.
// - Step multiplier picks 100 uA steps at 0 and 200 uA steps at 1, reset 1.
// - With step 0 the gain bits weigh 800, 400, 200 and 100 uA.
// - With step 1 the current is 1600 uA plus 800, 400, 200 uA for gain bits 2..0.
// - The six-bit offset adds 0 to 487.5 uA in 12.5 uA steps, bits 5 and 4 weigh 200 and 100.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_map.svh"
module pcr_regs
    import pcr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire pcr_byte_t   reg_wr_data,
    input  wire logic        reg_rd_en,
    output pcr_byte_t        reg_rd_data,
    output logic             reg_rd_valid,
    output logic             stage2_input_doubler_select,
    output logic [6:0]       stage2_divide_ratio,
    output logic             vcxo_feedback_halving_select,
    output logic             ext_vco_halving_select,
    output pcr_src_e         output_channel_source_select,
    output logic             first_stage_bypass_mode,
    output logic             stage2_pump_powerdown,
    output logic             stage2_pump_sink_enable,
    output logic             stage2_pump_step_double,
    output logic [4:0]       stage2_pump_current,
    output logic [5:0]       stage2_pump_offset_current
);
    pcr_byte_t  prediv_q, prediv_d;
    pcr_byte_t  srcbyp_q, srcbyp_d;
    pcr_byte_t  gain_q,   gain_d;
    pcr_byte_t  ofs_q,    ofs_d;
    pcr_byte_t  rd_data_q, rd_data_d;
    logic       rd_valid_q, rd_valid_d;
    logic [6:0] ratio_d, ratio_q;
    logic [4:0] cur_d, cur_q;
    logic [5:0] ocur_d, ocur_q;

    // Masked write keeps reserved positions at zero
    function automatic pcr_byte_t wr_field(input pcr_byte_t old, input pcr_byte_t data,
                                           input pcr_byte_t mask, input logic hit);
        wr_field = hit ? (data & mask) : old;
    endfunction

    always_comb begin
        prediv_d = wr_field(prediv_q, reg_wr_data, `PCR_MSK_PREDIV,
                            reg_wr_en && reg_addr == `PCR_OFS_PREDIV);
        srcbyp_d = wr_field(srcbyp_q, reg_wr_data, `PCR_MSK_SRC_BYP,
                            reg_wr_en && reg_addr == `PCR_OFS_SRC_BYP);
        gain_d   = wr_field(gain_q, reg_wr_data, `PCR_MSK_PUMP_GAIN,
                            reg_wr_en && reg_addr == `PCR_OFS_PUMP_GAIN);
        ofs_d    = wr_field(ofs_q, reg_wr_data, `PCR_MSK_PUMP_OFS,
                            reg_wr_en && reg_addr == `PCR_OFS_PUMP_OFS);
        // Read returns stored value; unmapped offsets read zero
        rd_valid_d = reg_rd_en;
        if (!reg_rd_en) begin
            rd_data_d = rd_data_q;
        end else if (reg_addr == `PCR_OFS_PREDIV) begin
            rd_data_d = prediv_q;
        end else if (reg_addr == `PCR_OFS_SRC_BYP) begin
            rd_data_d = srcbyp_q;
        end else if (reg_addr == `PCR_OFS_PUMP_GAIN) begin
            rd_data_d = gain_q;
        end else if (reg_addr == `PCR_OFS_PUMP_OFS) begin
            rd_data_d = ofs_q;
        end else begin
            rd_data_d = 8'h00;
        end
    end

    // Decode from next values so outputs settle with the register update
    pcr_decode u_decode (
        .prediv_reg     (prediv_d),
        .gain_reg       (gain_d),
        .ofs_reg        (ofs_d),
        .divide_ratio   (ratio_d),
        .pump_current   (cur_d),
        .offset_current (ocur_d)
    );

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prediv_q   <= `PCR_RST_PREDIV;
            srcbyp_q   <= `PCR_RST_SRC_BYP;
            gain_q     <= `PCR_RST_PUMP_GAIN;
            ofs_q      <= `PCR_RST_PUMP_OFS;
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
            ratio_q    <= `PCR_PREDIV_MIN;
            cur_q      <= `PCR_STEP_X2_BASE;
            ocur_q     <= 6'h00;
        end else begin
            prediv_q   <= prediv_d;
            srcbyp_q   <= srcbyp_d;
            gain_q     <= gain_d;
            ofs_q      <= ofs_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            ratio_q    <= ratio_d;
            cur_q      <= cur_d;
            ocur_q     <= ocur_d;
        end
    end

    assign reg_rd_data                  = rd_data_q;
    assign reg_rd_valid                 = rd_valid_q;
    assign stage2_input_doubler_select  = prediv_q[`PCR_BIT_DOUBLER];
    assign stage2_divide_ratio          = ratio_q;
    assign vcxo_feedback_halving_select = srcbyp_q[`PCR_BIT_FB_HALF];
    assign ext_vco_halving_select       = srcbyp_q[`PCR_BIT_EXT_HALF];
    assign output_channel_source_select =
        pcr_src_e'(srcbyp_q[`PCR_BIT_SRC_HI:`PCR_BIT_SRC_LO]);
    assign first_stage_bypass_mode      = srcbyp_q[`PCR_BIT_BYPASS];
    assign stage2_pump_powerdown        = gain_q[`PCR_BIT_PUMP_PD];
    assign stage2_pump_sink_enable      = gain_q[`PCR_BIT_SINK_EN];
    assign stage2_pump_step_double      = gain_q[`PCR_BIT_STEP_X2];
    assign stage2_pump_current          = cur_q;
    assign stage2_pump_offset_current   = ocur_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    doubler_ratio_a: assert property (
        stage2_input_doubler_select |-> stage2_divide_ratio == 7'h01)
        else $error("doubler active but pre-divider ratio not one");
    prediv_pass_a: assert property (
        !stage2_input_doubler_select && prediv_q[6:0] != 7'h00
        |-> stage2_divide_ratio == prediv_q[6:0])
        else $error("pre-divider ratio differs from stored field");
    fb_half_wr_a: assert property (
        reg_wr_en && reg_addr == 8'h21
        |=> vcxo_feedback_halving_select == $past(reg_wr_data[7]))
        else $error("feedback halving select not updated by write");
    ext_half_wr_a: assert property (
        reg_wr_en && reg_addr == 8'h21
        |=> ext_vco_halving_select == $past(reg_wr_data[6]))
        else $error("external VCO halving select not updated by write");
    src_sel_wr_a: assert property (
        reg_wr_en && reg_addr == 8'h21
        |=> output_channel_source_select == $past(reg_wr_data[5:4]))
        else $error("source select not updated by write");
    bypass_hold_a: assert property (
        !(reg_wr_en && reg_addr == 8'h21)
        |=> $stable(first_stage_bypass_mode))
        else $error("bypass mode changed without a write");
    pump_off_a: assert property (
        stage2_pump_powerdown |-> stage2_pump_current == 5'h00)
        else $error("powered-down pump reports current");
    sink_wr_a: assert property (
        reg_wr_en && reg_addr == 8'h28
        |=> stage2_pump_sink_enable == $past(reg_wr_data[5]))
        else $error("sink enable not updated by write");
    step_one_a: assert property (
        !stage2_pump_powerdown && !stage2_pump_step_double
        |-> stage2_pump_current == {1'b0, gain_q[3:0]})
        else $error("single-step pump current wrong");
    step_two_a: assert property (
        !stage2_pump_powerdown && stage2_pump_step_double
        |-> stage2_pump_current == 5'd16 + 5'(gain_q[2:0]) * 5'd2)
        else $error("double-step pump current wrong");
    offset_sum_a: assert property (
        stage2_pump_offset_current == 6'(ofs_q[5]) * 6'd16 + 6'(ofs_q[4]) * 6'd8
        + 6'(ofs_q[3]) * 6'd8 + 6'(ofs_q[2:0]))
        else $error("offset current sum wrong");
    reserved_rd_a: assert property (
        reg_rd_en && reg_addr == 8'h29
        |=> reg_rd_valid && reg_rd_data[7:6] == 2'b00)
        else $error("reserved offset bits read nonzero");
    rd_zero_a: assert property (
        reg_rd_en && reg_addr == 8'h21
        |=> reg_rd_data[2:0] == 3'b000)
        else $error("reserved source bits read nonzero");

    doubler_on_c: cover property (reg_wr_en && reg_addr == 8'h20 && reg_wr_data[7]
                                  ##1 stage2_input_doubler_select);
    max_pump_c:   cover property (stage2_pump_current == 5'd30);
    src_ref_c:    cover property (output_channel_source_select == PCR_SRC_REF_CLK
                                  && first_stage_bypass_mode);
    max_ofs_c:    cover property (stage2_pump_offset_current == 6'd39);
endmodule
`default_nettype wire

// ==== testbench/pcr_regs_tb_top.sv ====
// Self-checking bench for the PLL-1 input, bypass and pump registers
`timescale 1ns/1ps
`default_nettype none
`include "pcr_map.svh"
module pcr_regs_tb_top
    import pcr_pkg::*;
();
    localparam logic [7:0] OFS [5] = '{8'h20, 8'h21, 8'h28, 8'h29, 8'h33};
    localparam pcr_byte_t  MSK [4] = '{`PCR_MSK_PREDIV, `PCR_MSK_SRC_BYP,
                                       `PCR_MSK_PUMP_GAIN, `PCR_MSK_PUMP_OFS};
    localparam pcr_byte_t  RST [4] = '{`PCR_RST_PREDIV, `PCR_RST_SRC_BYP,
                                       `PCR_RST_PUMP_GAIN, `PCR_RST_PUMP_OFS};
    localparam pcr_byte_t  CRN [8] = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'h01, 8'h30, 8'h20, 8'h10};
    logic       ref_clk     = 1'h0;
    logic       reset       = 1'h1;
    logic [7:0] reg_addr    = 8'h00;
    logic       reg_wr_en   = 1'h0;
    pcr_byte_t  reg_wr_data = 8'h00;
    logic       reg_rd_en   = 1'h0;
    pcr_byte_t  reg_rd_data;
    logic       reg_rd_valid;
    logic       stage2_input_doubler_select;
    logic [6:0] stage2_divide_ratio;
    logic       vcxo_feedback_halving_select;
    logic       ext_vco_halving_select;
    pcr_src_e   output_channel_source_select;
    logic       first_stage_bypass_mode;
    logic       stage2_pump_powerdown;
    logic       stage2_pump_sink_enable;
    logic       stage2_pump_step_double;
    logic [4:0] stage2_pump_current;
    logic [5:0] stage2_pump_offset_current;
    pcr_byte_t  sh [4];
    int         fails       = 0;
    int         checks_done = 0;

    pcr_regs dut (.ref_clk, .reset, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
        .reg_rd_data, .reg_rd_valid, .stage2_input_doubler_select, .stage2_divide_ratio,
        .vcxo_feedback_halving_select, .ext_vco_halving_select, .output_channel_source_select,
        .first_stage_bypass_mode, .stage2_pump_powerdown, .stage2_pump_sink_enable,
        .stage2_pump_step_double, .stage2_pump_current, .stage2_pump_offset_current);

    always #25 ref_clk = ~ref_clk;

    function automatic int idx(logic [7:0] a);
        for (int k = 0; k < 4; k++) begin
            if (OFS[k] === a) return k;
        end
        return -1;
    endfunction
    // Field zero also decodes to one, a chosen reading
    function automatic logic [7:0] e_ratio(pcr_byte_t r);
        return (r[7] || r[6:0] == 7'h00) ? 8'h01 : {1'h0, r[6:0]};
    endfunction
    function automatic logic [7:0] e_cur(pcr_byte_t r);
        if (r[7]) return 8'h00;
        return r[4] ? 8'h10 + {4'h0, r[2:0], 1'h0} : {4'h0, r[3:0]};
    endfunction
    function automatic logic [7:0] e_ofs(pcr_byte_t r);
        return 8'h10 * r[5] + 8'h08 * r[4] + 8'h08 * r[3] + 8'h04 * r[2] + 8'h02 * r[1] + r[0];
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input pcr_byte_t d);
        int i;
        i = idx(a);
        @(negedge ref_clk);
        chk(reg_rd_valid, 1'h0, "rd_valid idle");
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'h1;
        @(negedge ref_clk);
        reg_wr_en = 1'h0;
        if (i >= 0) sh[i] = d & MSK[i];
    endtask
    task automatic rd(input logic [7:0] a);
        int i;
        i = idx(a);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd_en = 1'h1;
        @(negedge ref_clk);
        reg_rd_en = 1'h0;
        chk(reg_rd_valid, 1'h1, "rd_valid");
        chk(reg_rd_data, (i >= 0) ? sh[i] : 8'h00, "rd_data");
    endtask
    // Read beside a write must see the value from before it
    task automatic rw(input int i, input pcr_byte_t d);
        pcr_byte_t e;
        e = sh[i];
        @(negedge ref_clk);
        reg_addr = OFS[i];
        reg_wr_data = d;
        reg_wr_en = 1'h1;
        reg_rd_en = 1'h1;
        @(negedge ref_clk);
        reg_wr_en = 1'h0;
        reg_rd_en = 1'h0;
        chk(reg_rd_data, e, "read beside write");
        sh[i] = d & MSK[i];
    endtask
    task automatic check_outs;
        chk(stage2_input_doubler_select, sh[0][7], "doubler");
        chk(stage2_divide_ratio, e_ratio(sh[0]), "ratio");
        chk(vcxo_feedback_halving_select, sh[1][7], "fb half");
        chk(ext_vco_halving_select, sh[1][6], "ext half");
        chk(output_channel_source_select, sh[1][5:4], "source");
        chk(first_stage_bypass_mode, sh[1][3], "bypass");
        chk(stage2_pump_powerdown, sh[2][7], "pd");
        chk(stage2_pump_sink_enable, sh[2][5], "sink");
        chk(stage2_pump_step_double, sh[2][4], "step");
        chk(stage2_pump_current, e_cur(sh[2]), "current");
        chk(stage2_pump_offset_current, e_ofs(sh[3]), "offset");
    endtask
    task automatic check_reset;
        for (int i = 0; i < 4; i++) sh[i] = RST[i];
        check_outs;
        for (int i = 0; i < 5; i++) rd(OFS[i]);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        finish_test;
    end

    initial begin
        void'($urandom(46));
        repeat (10) @(negedge ref_clk);
        reset = 1'h0;
        check_reset;
        $display("test reset_values done");
        // Unmapped offset included, its writes must leave every field alone
        for (int i = 0; i < 5; i++) begin
            foreach (CRN[j]) begin
                wr(OFS[i], CRN[j]);
                check_outs;
                rd(OFS[i]);
            end
        end
        $display("test corner_values done");
        repeat (80) begin
            wr(OFS[$urandom % 5], 8'($urandom));
            check_outs;
            rd(OFS[$urandom % 5]);
        end
        $display("test random_values done");
        for (int i = 0; i < 4; i++) begin
            rw(i, ~sh[i]);
            check_outs;
        end
        $display("test read_beside_write done");
        @(negedge ref_clk);
        reset = 1'h1;
        @(negedge ref_clk);
        reset = 1'h0;
        check_reset;
        $display("test second_reset done");
        finish_test;
    end
endmodule
`default_nettype wire
